// File: vdsst_core.sv
// Purpose: Demand selection, ramping and partial stroke test for a valve actuator.
// Assumes: Analog inputs arrive as microamp codes synchronous to I_CLOCK.
// Notes: Ramp rates are position counts per clock cycle.
//
// Contract
// - The open command (input four, or input two when swapped) ramps the setpoint up at the open rate in run.
// - The close command (input three, or input one when swapped) ramps the setpoint down at the close rate.
// - Open and close asserted together start a partial stroke test, not an open or close.
// - The test ramps to the test position at the test rate, holds while both stay, then ramps back.
// - In discrete-only mode the setpoint follows only the discrete ramp.
// - In single-analog mode the setpoint is the lower of the discrete ramp and analog one.
// - In dual-analog mode the setpoint is the lowest of the discrete ramp and both analogs.
// - Removing the run permit steps the setpoint to shutdown at once in every mode.
// - In analog modes an active analog input under 2 mA steps the setpoint to shutdown.
// - Two outputs flag the measured position at its minimum and maximum ends.
// - A configurable output drives the fast drain valve solenoid.
// - Alarm and shutdown outputs report the condition to the turbine controller.
`timescale 1ns/100ps
module vdsst_core #(
    parameter int POS_W = vdsst_pkg::POS_W
) (
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic [3:0] I_DISC_IN,
    input wire logic I_RUN_PERMIT,
    input wire logic [15:0] I_AN1_UA,
    input wire logic [15:0] I_AN2_UA,
    input wire logic [POS_W-1:0] I_POS_MEAS,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HSEL,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [POS_W-1:0] O_SETPOINT,
    output logic O_AT_MIN,
    output logic O_AT_MAX,
    output logic O_DRAIN_VALVE_RUN,
    output logic O_ALARM,
    output logic O_SHUTDOWN,
    output logic O_IRQ
);
    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Scale microamps to position: 4 mA gives zero, 20 mA full stroke.
    function automatic logic [15:0] scale_ua(input logic [15:0] ua);
        logic [31:0] num;
        num = 32'h0;
        if (ua <= vdsst_pkg::UA_ZERO)
            return vdsst_pkg::POS_MIN;
        if (ua >= vdsst_pkg::UA_SPAN + vdsst_pkg::UA_ZERO)
            return vdsst_pkg::POS_MAX;
        num = 32'(ua - vdsst_pkg::UA_ZERO) * 32'(vdsst_pkg::POS_MAX);
        return 16'(num / 32'(vdsst_pkg::UA_SPAN));
    endfunction
    function automatic logic [15:0] min2(input logic [15:0] a, input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction

    // ------------------------------------------------------------------
    // Registers and next values
    // ------------------------------------------------------------------
    logic [5:0] ctrl_q, ctrl_d;
    logic [15:0] rate_open_q, rate_open_d, rate_close_q, rate_close_d;
    logic [15:0] test_pos_q, test_pos_d, test_rate_q, test_rate_d;
    logic [vdsst_pkg::N_EV-1:0] ist_q, ist_d, ien_q, ien_d;
    logic [31:0] rdata_q, rdata_d;
    logic ph_wr_q, ph_wr_d;
    logic [7:0] ph_addr_q, ph_addr_d;
    vdsst_pkg::vdsst_state_e st_q, st_d;
    logic [15:0] disc_q, disc_d, ret_q, ret_d, sp_q, sp_d;
    logic at_min_q, at_max_q, dv_q, alarm_q, shut_q, irq_q;
    logic at_min_d, at_max_d, dv_d, alarm_d, shut_d, irq_d;

    logic cmd_open, cmd_close, both, under, trip;
    logic [15:0] ramp_tgt, ramp_rate, ramp_out, an1_pos, an2_pos, sel;
    logic [vdsst_pkg::N_EV-1:0] ev;
    logic [1:0] mode;
    logic ap_valid;

    assign mode = ctrl_q[vdsst_pkg::C_MODE_LSB +: 2];
    // Input swap lets the open command sit on input two and close on input one.
    assign cmd_open = ctrl_q[vdsst_pkg::C_SWAP_OPEN] ? I_DISC_IN[1] : I_DISC_IN[3];
    assign cmd_close = ctrl_q[vdsst_pkg::C_SWAP_CLOSE] ? I_DISC_IN[0] : I_DISC_IN[2];
    assign both = cmd_open & cmd_close;
    assign an1_pos = scale_ua(I_AN1_UA);
    assign an2_pos = scale_ua(I_AN2_UA);
    // Under-range counts analog one in every mode but discrete-only, and analog two in dual mode only.
    assign under = ((mode != vdsst_pkg::M_DISC) && (I_AN1_UA < vdsst_pkg::UA_TRIP))
        || ((mode == vdsst_pkg::M_AN2) && (I_AN2_UA < vdsst_pkg::UA_TRIP));
    assign trip = ~I_RUN_PERMIT | ~ctrl_q[vdsst_pkg::C_RUN] | under;

    // ------------------------------------------------------------------
    // Stroke state machine and discrete ramp
    // ------------------------------------------------------------------
    // The ramp helper is shared by open, close and test moves.
    vdsst_ramp #(.W(16)) u_ramp (
        .i_pos(disc_q),
        .i_target(ramp_tgt),
        .i_rate(ramp_rate),
        .o_next(ramp_out)
    );

    always_comb
    begin
        st_d = st_q;
        ret_d = ret_q;
        ramp_tgt = disc_q;
        ramp_rate = vdsst_pkg::RATE_RST;
        unique case (st_q)
            vdsst_pkg::S_STOP:
            begin
                st_d = vdsst_pkg::S_RUN;
            end
            vdsst_pkg::S_RUN:
            begin
                if (both)
                begin
                    st_d = vdsst_pkg::S_T_DOWN;
                    ret_d = disc_q;
                end
                else if (cmd_open)
                begin
                    ramp_tgt = vdsst_pkg::POS_MAX;
                    ramp_rate = rate_open_q;
                end
                else if (cmd_close)
                begin
                    ramp_tgt = vdsst_pkg::POS_MIN;
                    ramp_rate = rate_close_q;
                end
            end
            vdsst_pkg::S_T_DOWN, vdsst_pkg::S_T_HOLD:
            begin
                ramp_tgt = test_pos_q;
                ramp_rate = test_rate_q;
                if (!both)
                    st_d = vdsst_pkg::S_T_BACK;
                else if (ramp_out == test_pos_q)
                    st_d = vdsst_pkg::S_T_HOLD;
            end
            vdsst_pkg::S_T_BACK:
            begin
                ramp_tgt = ret_q;
                ramp_rate = test_rate_q;
                if (ramp_out == ret_q)
                    st_d = vdsst_pkg::S_RUN;
            end
        endcase
        disc_d = ramp_out;
        // Shutdown steps straight to closed, no ramp, from any state.
        if (trip)
        begin
            st_d = vdsst_pkg::S_STOP;
            disc_d = vdsst_pkg::POS_MIN;
        end
    end

    // ------------------------------------------------------------------
    // Low signal select and pin outputs
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (mode)
            vdsst_pkg::M_AN1: sel = min2(disc_q, an1_pos);
            vdsst_pkg::M_AN2: sel = min2(disc_q, min2(an1_pos, an2_pos));
            default: sel = disc_q;
        endcase
        sp_d = trip ? vdsst_pkg::POS_MIN : sel;
        at_min_d = (I_POS_MEAS == vdsst_pkg::POS_MIN);
        at_max_d = (I_POS_MEAS == vdsst_pkg::POS_MAX);
        // Solenoid energised keeps the drain valve shut, so drop it on trip.
        dv_d = ctrl_q[vdsst_pkg::C_DUMP_EN] & ~trip;
        alarm_d = under | (st_q != vdsst_pkg::S_RUN);
        shut_d = trip;
    end

    // ------------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------------
    assign ev[vdsst_pkg::E_TRIP] = trip & ~shut_q;
    assign ev[vdsst_pkg::E_UNDER] = under;
    assign ev[vdsst_pkg::E_TEST_GO] = (st_q == vdsst_pkg::S_RUN) & both & ~trip;
    assign ev[vdsst_pkg::E_TEST_END] = (st_q == vdsst_pkg::S_T_BACK) & (st_d == vdsst_pkg::S_RUN);

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------------
    assign ap_valid = HSEL & HREADY & HTRANS[1];

    always_comb
    begin
        ctrl_d = ctrl_q;
        rate_open_d = rate_open_q;
        rate_close_d = rate_close_q;
        test_pos_d = test_pos_q;
        test_rate_d = test_rate_q;
        ien_d = ien_q;
        ist_d = ist_q;
        ph_wr_d = ap_valid & HWRITE;
        ph_addr_d = HADDR;
        rdata_d = 32'h0;
        // Clear first, then set, so an event in the clear cycle survives.
        if (ph_wr_q && ph_addr_q == vdsst_pkg::A_IRQ_CLR)
            ist_d = ist_q & ~HWDATA[vdsst_pkg::N_EV-1:0];
        ist_d = ist_d | ev;
        if (ph_wr_q)
        begin
            unique case (ph_addr_q)
                vdsst_pkg::A_CTRL: ctrl_d = HWDATA[5:0];
                vdsst_pkg::A_RATE_OPEN: rate_open_d = HWDATA[15:0];
                vdsst_pkg::A_RATE_CLOSE: rate_close_d = HWDATA[15:0];
                vdsst_pkg::A_TEST_POS: test_pos_d = HWDATA[15:0];
                vdsst_pkg::A_TEST_RATE: test_rate_d = HWDATA[15:0];
                vdsst_pkg::A_IRQ_EN: ien_d = HWDATA[vdsst_pkg::N_EV-1:0];
                default: ;
            endcase
        end
        if (ap_valid && !HWRITE)
        begin
            unique case (HADDR)
                vdsst_pkg::A_CTRL: rdata_d = {26'h0, ctrl_q};
                vdsst_pkg::A_RATE_OPEN: rdata_d = {16'h0, rate_open_q};
                vdsst_pkg::A_RATE_CLOSE: rdata_d = {16'h0, rate_close_q};
                vdsst_pkg::A_TEST_POS: rdata_d = {16'h0, test_pos_q};
                vdsst_pkg::A_TEST_RATE: rdata_d = {16'h0, test_rate_q};
                vdsst_pkg::A_SETPOINT: rdata_d = {16'h0, sp_q};
                vdsst_pkg::A_STATUS: rdata_d = {22'h0, st_q, shut_q, alarm_q, at_max_q, at_min_q, dv_q};
                vdsst_pkg::A_IRQ_STAT: rdata_d = {28'h0, ist_q};
                vdsst_pkg::A_IRQ_EN: rdata_d = {28'h0, ien_q};
                default: rdata_d = 32'h0;
            endcase
        end
        irq_d = |(ist_d & ien_d);
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            ctrl_q <= vdsst_pkg::CTRL_RST;
            rate_open_q <= vdsst_pkg::RATE_RST;
            rate_close_q <= vdsst_pkg::RATE_RST;
            test_pos_q <= vdsst_pkg::TEST_POS_RST;
            test_rate_q <= vdsst_pkg::RATE_RST;
            ist_q <= '0;
            ien_q <= '0;
            rdata_q <= 32'h0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= 8'h0;
            st_q <= vdsst_pkg::S_STOP;
            disc_q <= vdsst_pkg::POS_MIN;
            ret_q <= vdsst_pkg::POS_MIN;
            sp_q <= vdsst_pkg::POS_MIN;
            at_min_q <= 1'b0;
            at_max_q <= 1'b0;
            dv_q <= 1'b0;
            alarm_q <= 1'b0;
            shut_q <= 1'b1;
            irq_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rate_open_q <= rate_open_d;
            rate_close_q <= rate_close_d;
            test_pos_q <= test_pos_d;
            test_rate_q <= test_rate_d;
            ist_q <= ist_d;
            ien_q <= ien_d;
            rdata_q <= rdata_d;
            ph_wr_q <= ph_wr_d;
            ph_addr_q <= ph_addr_d;
            st_q <= st_d;
            disc_q <= disc_d;
            ret_q <= ret_d;
            sp_q <= sp_d;
            at_min_q <= at_min_d;
            at_max_q <= at_max_d;
            dv_q <= dv_d;
            alarm_q <= alarm_d;
            shut_q <= shut_d;
            irq_q <= irq_d;
        end
    end

    assign HRDATA = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign O_SETPOINT = sp_q;
    assign O_AT_MIN = at_min_q;
    assign O_AT_MAX = at_max_q;
    assign O_DRAIN_VALVE_RUN = dv_q;
    assign O_ALARM = alarm_q;
    assign O_SHUTDOWN = shut_q;
    assign O_IRQ = irq_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_trip_step;
        @(posedge I_CLOCK) disable iff (I_RST) !I_RUN_PERMIT |=> (O_SETPOINT == 16'h0) && O_SHUTDOWN;
    endproperty
    a_trip_step: assert property (p_trip_step) else $error("Run permit loss did not step closed.");
    property p_under;
        @(posedge I_CLOCK) disable iff (I_RST)
            (mode == vdsst_pkg::M_AN1 && I_AN1_UA < vdsst_pkg::UA_TRIP) |=> O_SHUTDOWN;
    endproperty
    a_under: assert property (p_under) else $error("Analog under-range did not shut down.");
    sequence s_test_start;
        st_q == vdsst_pkg::S_RUN && both && !trip;
    endsequence
    property p_test;
        @(posedge I_CLOCK) disable iff (I_RST) s_test_start |=> st_q == vdsst_pkg::S_T_DOWN;
    endproperty
    a_test: assert property (p_test) else $error("Both commands did not start a test.");
    property p_open;
        @(posedge I_CLOCK) disable iff (I_RST)
            (st_q == vdsst_pkg::S_RUN && cmd_open && !cmd_close && !trip
             && (vdsst_pkg::POS_MAX - disc_q) > rate_open_q)
            |=> disc_q == $past(disc_q) + $past(rate_open_q);
    endproperty
    a_open: assert property (p_open) else $error("Open ramp step wrong.");
    property p_close;
        @(posedge I_CLOCK) disable iff (I_RST)
            (st_q == vdsst_pkg::S_RUN && cmd_close && !cmd_open && !trip && disc_q > rate_close_q)
            |=> disc_q == $past(disc_q) - $past(rate_close_q);
    endproperty
    a_close: assert property (p_close) else $error("Close ramp step wrong.");
    property p_hold;
        @(posedge I_CLOCK) disable iff (I_RST)
            (st_q == vdsst_pkg::S_T_HOLD && both && !trip) |=> disc_q == test_pos_q;
    endproperty
    a_hold: assert property (p_hold) else $error("Test hold left the test position.");
    property p_lss;
        @(posedge I_CLOCK) disable iff (I_RST)
            (!trip && mode == vdsst_pkg::M_AN2) |=> O_SETPOINT <= $past(disc_q);
    endproperty
    a_lss: assert property (p_lss) else $error("Low select exceeded discrete demand.");
    property p_ends;
        @(posedge I_CLOCK) disable iff (I_RST)
            (!$past(I_RST) && I_POS_MEAS == 16'h0) |=> O_AT_MIN && !O_AT_MAX;
    endproperty
    a_ends: assert property (p_ends) else $error("Minimum end flag missing.");
endmodule // vdsst_core

// File: vdsst_pkg.sv
// Purpose: Shared constants for the valve demand select and stroke test block.
// Assumes: Positions are unsigned fractions of full stroke, 0 closed, max open.
// Notes: Register offsets are byte addresses on an AHB-Lite slave.
package vdsst_pkg;
    // ------------------------------------------------------------------
    // Widths and scaling
    // ------------------------------------------------------------------
    localparam int POS_W = 16;
    localparam int ADC_W = 16;
    localparam logic [15:0] POS_MAX = 16'hffff;
    localparam logic [15:0] POS_MIN = 16'h0000;
    // Analog codes are microamps: 2 mA trip, 4 mA zero, 20 mA full span.
    localparam logic [15:0] UA_TRIP = 16'h07d0;
    localparam logic [15:0] UA_ZERO = 16'h0fa0;
    localparam logic [15:0] UA_SPAN = 16'h3e80;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_RATE_OPEN = 8'h04;
    localparam logic [7:0] A_RATE_CLOSE = 8'h08;
    localparam logic [7:0] A_TEST_POS = 8'h0c;
    localparam logic [7:0] A_TEST_RATE = 8'h10;
    localparam logic [7:0] A_SETPOINT = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_IRQ_STAT = 8'h1c;
    localparam logic [7:0] A_IRQ_EN = 8'h20;
    localparam logic [7:0] A_IRQ_CLR = 8'h24;
    // Control fields.
    localparam int C_MODE_LSB = 0;
    localparam int C_SWAP_OPEN = 2;
    localparam int C_SWAP_CLOSE = 3;
    localparam int C_DUMP_EN = 4;
    localparam int C_RUN = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [15:0] RATE_RST = 16'h0010;
    localparam logic [15:0] TEST_POS_RST = 16'hcccc;
    // Demand modes.
    localparam logic [1:0] M_DISC = 2'h0;
    localparam logic [1:0] M_AN1 = 2'h1;
    localparam logic [1:0] M_AN2 = 2'h2;
    // Interrupt event bits.
    localparam int E_TRIP = 0;
    localparam int E_UNDER = 1;
    localparam int E_TEST_GO = 2;
    localparam int E_TEST_END = 3;
    localparam int N_EV = 4;
    // Stroke states, one-hot.
    typedef enum logic [4:0] {
        S_STOP = 5'h01,
        S_RUN = 5'h02,
        S_T_DOWN = 5'h04,
        S_T_HOLD = 5'h08,
        S_T_BACK = 5'h10
    } vdsst_state_e;
endpackage

// File: vdsst_ramp.sv
// Purpose: Steps a position toward a target by at most a given rate per clock.
// Assumes: Rate of zero freezes the position.
// Notes: Pure combinational, reused by the main block.
`timescale 1ns/100ps
module vdsst_ramp #(
    parameter int W = 16
) (
    input wire logic [W-1:0] i_pos,
    input wire logic [W-1:0] i_target,
    input wire logic [W-1:0] i_rate,
    output logic [W-1:0] o_next
);
    // ------------------------------------------------------------------
    // Slew limiter
    // ------------------------------------------------------------------
    // The gap is compared first so the step never overshoots the target.
    always_comb
    begin
        if (i_target > i_pos)
        begin
            o_next = ((i_target - i_pos) > i_rate) ? i_pos + i_rate : i_target;
        end
        else
        begin
            o_next = ((i_pos - i_target) > i_rate) ? i_pos - i_rate : i_target;
        end
    end
endmodule // vdsst_ramp

// File: vdsst_far_model.sv
// Purpose: Far-side model of the turbine controller and the valve position feedback.
// Assumes: Bench requests are levels; the model launches them on the next rising edge.
// Notes: With slow set, the fed-back position only closes half the gap each clock.
`timescale 1ns/100ps
module vdsst_far_model (
    input wire logic i_clk,
    input wire logic i_open,
    input wire logic i_close,
    input wire logic i_test,
    input wire logic i_permit,
    input wire logic i_slow,
    input wire logic [15:0] i_sp,
    output logic [3:0] o_disc,
    output logic o_permit,
    output logic [15:0] o_pos
);
    // ------------------------------------------------------------------
    // Command and feedback drive
    // ------------------------------------------------------------------
    // A test request raises both commands on one edge, so the device never sees
    // a lone open or close on the way into the test.
    always_ff @(posedge i_clk)
    begin
        o_disc <= {i_open | i_test, i_close | i_test, 2'h0};
        o_permit <= i_permit;
        o_pos <= i_slow ? ((o_pos >> 1) + (i_sp >> 1)) : i_sp;
    end
endmodule // vdsst_far_model

// File: valve_demand_select_and_stroke_test_tb.sv
// Purpose: Self-checking bench for the demand select and stroke test block.
// Assumes: Zero wait-state slave; registers hold the low bits of each word.
// Notes: Analog values are compared at both ends and at mid-scale, where the rounded-down result is judged.
`timescale 1ns/100ps
module valve_demand_select_and_stroke_test_tb;
    logic clk, rst, hwrite, hsel, hready, hresp, irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [15:0] an1, an2, sp, pos, v;
    logic [3:0] disc;
    logic open, close, test, permit, slow, permit_in, at_min, at_max, dv, alarm, shut;
    int bad_count, checks;
    vdsst_far_model u_vdsst_far_model (.i_clk(clk), .i_open(open), .i_close(close),
        .i_test(test), .i_permit(permit), .i_slow(slow), .i_sp(sp), .o_disc(disc),
        .o_permit(permit_in), .o_pos(pos));
    vdsst_core u_vdsst_core (.I_CLOCK(clk), .I_RST(rst), .I_DISC_IN(disc),
        .I_RUN_PERMIT(permit_in), .I_AN1_UA(an1), .I_AN2_UA(an2), .I_POS_MEAS(pos),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HSEL(hsel),
        .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .O_SETPOINT(sp), .O_AT_MIN(at_min), .O_AT_MAX(at_max),
        .O_DRAIN_VALVE_RUN(dv), .O_ALARM(alarm), .O_SHUTDOWN(shut), .O_IRQ(irq));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // The verdict is printed in one place only, also when a wait runs out.
    task automatic complete_run();
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One AHB-Lite single transfer; the address phase is held until hready is seen.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a; hsize <= 3'h2;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (hready === 1'b1) break;
        end
        if (n >= 50) begin chk(1'b0, 1'b1); complete_run(); end
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (hready === 1'b1) break;
        end
        rd = hrdata;
        chk(hresp, 1'b0);
        if (n >= 50) begin chk(1'b0, 1'b1); complete_run(); end
    endtask
    // Waits for the setpoint to reach a value, under a bounded count.
    task automatic wait_sp(input logic [15:0] t);
        int n;
        for (n = 0; n < 3000 && sp !== t; n++) @(negedge clk);
        chk(sp, t);
        if (sp !== t) complete_run();
    endtask
    // Compares the setpoint change over one clock with the expected step.
    task automatic step(input logic [15:0] d);
        repeat (4) @(negedge clk);
        v = sp;
        @(negedge clk);
        chk(16'(sp - v), d);
    endtask
    // ------------------------------------------------------------------
    // Clock, reset and the main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        {hwrite, hsel, open, close, test, permit, slow} = '0;
        {haddr, htrans, hsize, hwdata, bad_count, checks} = '0;
        an1 = 16'h4e20; an2 = 16'h4e20; rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({sp, shut, dv}, {16'h0000, 1'b1, 1'b0});
        bus(0, vdsst_pkg::A_CTRL, 0); chk(rd, 32'h0);
        bus(0, vdsst_pkg::A_RATE_OPEN, 0); chk(rd, 32'h10);
        bus(0, vdsst_pkg::A_TEST_POS, 0); chk(rd, 32'hcccc);
        bus(0, 8'h30, 0); chk(rd, 32'h0);
        bus(1, vdsst_pkg::A_RATE_OPEN, 32'h100);
        bus(1, vdsst_pkg::A_RATE_CLOSE, 32'h80);
        bus(1, vdsst_pkg::A_TEST_RATE, 32'h40);
        bus(1, vdsst_pkg::A_TEST_POS, 32'h8000);
        bus(1, vdsst_pkg::A_SETPOINT, 32'h1234);
        bus(0, vdsst_pkg::A_SETPOINT, 0); chk(rd, 32'h0);
        bus(1, vdsst_pkg::A_CTRL, 32'h30);
        permit <= 1'b1;
        repeat (4) @(negedge clk);
        chk({shut, dv}, 2'b01);
        // Open ramp, then the maximum end flag.
        open <= 1'b1;
        step(16'h0100);
        wait_sp(16'hffff);
        open <= 1'b0;
        repeat (3) @(negedge clk);
        chk({at_max, at_min}, 2'b10);
        // Close part way, then a stroke test from there with slow feedback.
        close <= 1'b1;
        step(16'hff80);
        for (int n = 0; n < 3000 && sp > 16'hc000; n++) @(negedge clk);
        chk(sp <= 16'hc000, 1'b1);
        if (sp > 16'hc000) complete_run();
        close <= 1'b0;
        repeat (3) @(negedge clk);
        v = sp;
        bus(1, vdsst_pkg::A_IRQ_CLR, 32'hf);
        bus(1, vdsst_pkg::A_IRQ_EN, 32'h0);
        slow <= 1'b1; test <= 1'b1;
        step(16'hffc0);
        wait_sp(16'h8000);
        repeat (20) @(negedge clk);
        chk(sp, 16'h8000);
        test <= 1'b0;
        wait_sp(v);
        bus(0, vdsst_pkg::A_IRQ_STAT, 0); chk(rd & 32'hc, 32'hc);
        chk(irq, 1'b0);
        bus(1, vdsst_pkg::A_IRQ_EN, 32'hc);
        repeat (2) @(negedge clk);
        chk(irq, 1'b1);
        bus(1, vdsst_pkg::A_IRQ_CLR, 32'hf);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        // Close to the minimum end.
        slow <= 1'b0; close <= 1'b1;
        wait_sp(16'h0000);
        close <= 1'b0;
        repeat (3) @(negedge clk);
        chk({at_max, at_min}, 2'b01);
        open <= 1'b1;
        wait_sp(16'hffff);
        open <= 1'b0;
        // Low select against the analog demands at the 4 mA and 20 mA ends.
        bus(1, vdsst_pkg::A_CTRL, 32'h31);
        an1 <= 16'h0fa0;
        wait_sp(16'h0000);
        chk(shut, 1'b0);
        // Mid-scale current gives half stroke, rounded down.
        @(posedge clk);
        an1 <= 16'h2ee0;
        wait_sp(16'h7fff);
        @(posedge clk);
        an1 <= 16'h4e20;
        wait_sp(16'hffff);
        bus(1, vdsst_pkg::A_CTRL, 32'h32);
        an2 <= 16'h0fa0;
        wait_sp(16'h0000);
        @(posedge clk);
        an2 <= 16'h4e20;
        wait_sp(16'hffff);
        // Discrete-only mode ignores a dead analog input.
        bus(1, vdsst_pkg::A_CTRL, 32'h30);
        an1 <= 16'h0000;
        repeat (5) @(negedge clk);
        chk({sp, shut}, {16'hffff, 1'b0});
        @(posedge clk);
        an1 <= 16'h4e20;
        // Run permit removal steps to shutdown at once.
        permit <= 1'b0;
        repeat (4) @(negedge clk);
        chk({sp, shut, alarm, dv}, {16'h0000, 3'b110});
        bus(0, vdsst_pkg::A_IRQ_STAT, 0); chk(rd & 32'h1, 32'h1);
        permit <= 1'b1;
        bus(1, vdsst_pkg::A_CTRL, 32'h32);
        open <= 1'b1;
        wait_sp(16'hffff);
        // Just under 2 mA on analog two trips in dual mode.
        @(posedge clk);
        an2 <= 16'h07cf;
        repeat (4) @(negedge clk);
        chk({sp, shut, alarm}, {16'h0000, 2'b11});
        bus(0, vdsst_pkg::A_IRQ_STAT, 0); chk(rd & 32'h2, 32'h2);
        complete_run();
    end
endmodule // valve_demand_select_and_stroke_test_tb
